// *** logic/acsp_spi_port.sv ***
/*
 * serial configuration port slave of a multi-core converter, sampled on mclk_i.
 * assumes the master keeps sclk slow against mclk_i and drives one wire only.
 */
// How it works
// RULE1: master limits sclk to sample rate /16, /66
// RULE2: three-wire default; port_setup bit7 enables four-wire
// RULE3: device is only a half-duplex slave
// RULE4: master shares bus only in four-wire mode
// RULE5: master reads from one slave at once
// RULE6: instruction starts at first sclk after select
// RULE7: msb first unless port_setup bit6 set
// RULE8: address counts up msb-first, down lsb-first
// RULE9: read bit, two count bits, 13-bit address
// RULE10: count code gives one, two, three, many bytes
// RULE11: data bytes continue while select stays low
// RULE12: master pauses only at permitted byte boundaries
// RULE13: late pause in long transfer aborts it
// RULE14: master avoids undefined registers and values
// RULE15: soft reset bit restores all defaults
// RULE16: master writes port_setup mirrored, bit4 high
// RULE17: burst stop address ends a long burst
// RULE18: die identifier and revision are readable
// RULE19: converter select picks one core, 00 none
// RULE20: indexed read without valid select returns AD
// RULE21: per-core offset trims, 0x80 is zero
// RULE22: trims load calibration values; master read-modify-writes
// RULE23: four-bit coarse gain field
// RULE24: eight-bit medium and fine gain trims
// RULE25: three-wire pin driven only in read data
// RULE26: four-wire output released while deselected
`timescale 1ns/1ps
`include "acsp_cfg.svh"
module acsp_spi_port #(
	parameter int NUM_CONV = 2,
	parameter logic [7:0] DIE_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DIE_REV = 8'h01 // arbitrary value
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// serial link pins
	input wire logic sclk_i,
	input wire logic chip_select_n_i,
	input wire logic serial_in_pin_i,
	output logic serial_in_pin_o,
	output logic serial_in_pin_oe_o,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	// converter cores
	input acsp_pkg::acsp_trim_t cal_trim_i [NUM_CONV],
	output acsp_pkg::acsp_trim_t trim_o [NUM_CONV],
	output logic four_wire_enable_o
);
	////////////////////////////////////////////////////////////////////////
	// synchronisers and edge detect
	logic [1:0] sclk_sy_q; // two-flop chain for sclk
	logic [1:0] csn_sy_q; // two-flop chain for select
	logic [1:0] din_sy_q; // two-flop chain for data in
	logic sclk_p_q; // sclk one cycle later
	logic csn_p_q; // select one cycle later

	// only stage 0 feeds stage 1; logic reads stage 1 and later
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sclk_sy_q <= 2'h0;
			csn_sy_q <= 2'h3;
			din_sy_q <= 2'h0;
			sclk_p_q <= 1'h0;
			csn_p_q <= 1'h1;
		end else begin
			sclk_sy_q <= {sclk_sy_q[0], sclk_i};
			csn_sy_q <= {csn_sy_q[0], chip_select_n_i};
			din_sy_q <= {din_sy_q[0], serial_in_pin_i};
			sclk_p_q <= sclk_sy_q[1];
			csn_p_q <= csn_sy_q[1];
		end
	end

	wire logic csn_s = csn_sy_q[1];
	wire logic din_s = din_sy_q[1];
	// edges only count while selected, so a paused link is deaf
	wire logic sclk_rise = sclk_sy_q[1] & ~sclk_p_q & ~csn_s;
	wire logic sclk_fall = ~sclk_sy_q[1] & sclk_p_q & ~csn_s;
	wire logic csn_fall = ~csn_s & csn_p_q;
	wire logic csn_rise = csn_s & ~csn_p_q;

	////////////////////////////////////////////////////////////////////////
	// state and shift registers
	acsp_pkg::acsp_state_t st_q, st_d;
	logic [15:0] sh_q; // incoming bits, both orders
	logic [3:0] bit_cnt_q; // bits taken in current phase
	acsp_pkg::acsp_instr_t ins_q; // latched instruction
	logic [1:0] nbytes_q; // data bytes done, saturates
	logic [7:0] tx_q; // byte being sent
	logic out_q; // serial output bit
	logic [7:0] port_q; // port_setup
	logic [7:0] burst_q; // burst_stop_address
	logic [7:0] sel_q; // converter_select
	acsp_pkg::acsp_trim_t trim_q [NUM_CONV];

	wire logic lsb_first = port_q[`ACSP_PS_LSB_BIT];
	wire logic four_wire = port_q[`ACSP_PS_4W_BIT];
	wire logic in_instr = st_q == acsp_pkg::ST_INSTR;
	wire logic in_data = st_q == acsp_pkg::ST_DATA;

	// lsb-first fills from the top, msb-first from the bottom
	wire logic [15:0] sh_d = lsb_first ? {din_s, sh_q[15:1]} : {sh_q[14:0], din_s}; // see RULE7
	wire logic [7:0] rx_byte = lsb_first ? sh_d[15:8] : sh_d[7:0]; // see RULE7
	wire acsp_pkg::acsp_instr_t ins_new = acsp_pkg::acsp_instr_t'(sh_d); // see RULE9

	wire logic instr_end = sclk_rise & in_instr & (bit_cnt_q == `ACSP_INSTR_LAST);
	wire logic byte_end = sclk_rise & in_data & (bit_cnt_q == `ACSP_BYTE_LAST);

	// next address of a burst
	wire logic [`ACSP_ADDR_W-1:0] addr_step = lsb_first ? ins_q.addr - 1'b1 : ins_q.addr + 1'b1; // see RULE8
	// read address: new instruction or next burst address
	wire logic [`ACSP_ADDR_W-1:0] rd_addr = in_instr ? ins_new.addr : addr_step;

	////////////////////////////////////////////////////////////////////////
	// write decode
	wire logic wr_en = byte_end & ~ins_q.rd; // see RULE11
	wire logic [`ACSP_ADDR_W-1:0] wa = ins_q.addr;
	wire logic soft_rst = wr_en & (wa == `ACSP_A_PORT) & rx_byte[`ACSP_PS_SRST_BIT]; // see RULE15
	wire logic regs_rst = rst_i | soft_rst;
	localparam logic [7:0] CONV_MASK = 8'((1 << NUM_CONV) - 1);
	// exactly one existing core selected
	wire logic sel_ok = $onehot(sel_q) & ((sel_q & ~CONV_MASK) == 8'h00); // see RULE19
	wire logic idx_hit = (wa >= `ACSP_A_OFS_LG) & (wa <= `ACSP_A_GAIN_SM);
	wire logic idx_wr = wr_en & idx_hit & sel_ok;

	// last byte: count reached, or burst reached stop address
	wire logic cnt_many = ins_q.cnt == `ACSP_CNT_MANY;
	wire logic last_byte = cnt_many ? (wa[7:0] == burst_q) : (nbytes_q == ins_q.cnt); // see RULE10
	// select released: mid-byte aborts (bit 8 of the instruction is a boundary), long burst aborts once a data byte is done
	wire logic abort = (bit_cnt_q[2:0] != 3'h0) | (in_data & cnt_many & (nbytes_q != 2'h0)); // see RULE13

	////////////////////////////////////////////////////////////////////////
	// serial state machine
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			acsp_pkg::ST_IDLE: begin
				// waits for a fresh select, never starts on its own
				if (csn_fall) begin
					st_d = acsp_pkg::ST_INSTR; // see RULE6 // see RULE3
				end
			end
			acsp_pkg::ST_INSTR: begin
				if (csn_rise && abort) begin
					st_d = acsp_pkg::ST_IDLE; // see RULE13
				end else if (instr_end) begin
					st_d = acsp_pkg::ST_DATA;
				end
			end
			acsp_pkg::ST_DATA: begin
				if (csn_rise && abort) begin
					st_d = acsp_pkg::ST_IDLE; // see RULE13
				end else if (soft_rst || (byte_end && last_byte)) begin
					st_d = acsp_pkg::ST_DONE; // see RULE17
				end
			end
			acsp_pkg::ST_DONE: begin
				// ignore clocks until select goes high
				if (csn_s) begin
					st_d = acsp_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q <= acsp_pkg::ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// bit counter and shifter; a fresh select clears the count
	always_ff @(posedge mclk_i) begin
		if (rst_i || csn_fall && st_q == acsp_pkg::ST_IDLE) begin
			bit_cnt_q <= 4'h0;
			sh_q <= 16'h0000;
		end else if (instr_end || byte_end) begin
			bit_cnt_q <= 4'h0;
			sh_q <= sh_d;
		end else if (sclk_rise && (in_instr || in_data)) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			sh_q <= sh_d;
		end
	end

	// instruction, address walk and byte count
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ins_q <= '0;
			nbytes_q <= 2'h0;
		end else if (instr_end) begin
			ins_q <= ins_new; // see RULE9
			nbytes_q <= 2'h0;
		end else if (byte_end) begin
			ins_q.addr <= addr_step; // see RULE8
			nbytes_q <= (nbytes_q == `ACSP_CNT_MANY) ? nbytes_q : nbytes_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge mclk_i) begin
		if (regs_rst) begin
			port_q <= `ACSP_PS_RST; // see RULE15
			burst_q <= `ACSP_BURST_RST;
			sel_q <= `ACSP_SEL_RST; // see RULE19
		end else if (wr_en) begin
			// soft reset bit and its mirror are not kept
			if (wa == `ACSP_A_PORT) begin
				port_q <= rx_byte & `ACSP_PS_KEEP_MASK; // see RULE2
			end
			if (wa == `ACSP_A_BURST) begin
				burst_q <= rx_byte; // see RULE17
			end
			if (wa == `ACSP_A_CONV_SEL) begin
				sel_q <= rx_byte;
			end
		end
	end

	// per-core trims, loaded from calibration on any reset
	for (genvar c = 0; c < NUM_CONV; c++) begin : g_conv
		wire logic wr_c = idx_wr & sel_q[c];
		always_ff @(posedge mclk_i) begin
			if (regs_rst) begin
				trim_q[c] <= cal_trim_i[c]; // see RULE22
			end else if (wr_c) begin
				if (wa == `ACSP_A_OFS_LG) begin
					trim_q[c].ofs_large <= rx_byte; // see RULE21
				end
				if (wa == `ACSP_A_OFS_SM) begin
					trim_q[c].ofs_small <= rx_byte; // see RULE21
				end
				if (wa == `ACSP_A_GAIN_LG) begin
					trim_q[c].gain_large <= rx_byte[`ACSP_GAIN_LG_W-1:0]; // see RULE23
				end
				if (wa == `ACSP_A_GAIN_MD) begin
					trim_q[c].gain_mid <= rx_byte; // see RULE24
				end
				if (wa == `ACSP_A_GAIN_SM) begin
					trim_q[c].gain_small <= rx_byte; // see RULE24
				end
			end
		end
		assign trim_o[c] = trim_q[c];
	end

	////////////////////////////////////////////////////////////////////////
	// read path
	acsp_pkg::acsp_trim_t sel_trim; // trims of the selected core
	logic [7:0] rd_byte;

	// at most one bit of sel_q is set when this is used
	always_comb begin
		sel_trim = '0;
		for (int c = 0; c < NUM_CONV; c++) begin
			if (sel_q[c]) begin
				sel_trim = sel_trim | trim_q[c];
			end
		end
	end

	// byte answered for rd_addr; undefined space reads zero
	always_comb begin
		rd_byte = `ACSP_UNMAPPED;
		unique case (rd_addr)
			`ACSP_A_PORT: rd_byte = port_q;
			`ACSP_A_BURST: rd_byte = burst_q;
			`ACSP_A_DIE_ID: rd_byte = DIE_ID; // see RULE18
			`ACSP_A_DIE_REV: rd_byte = DIE_REV; // see RULE18
			`ACSP_A_CONV_SEL: rd_byte = sel_q;
			`ACSP_A_OFS_LG: rd_byte = sel_trim.ofs_large;
			`ACSP_A_OFS_SM: rd_byte = sel_trim.ofs_small;
			`ACSP_A_GAIN_LG: rd_byte = 8'(sel_trim.gain_large);
			`ACSP_A_GAIN_MD: rd_byte = sel_trim.gain_mid;
			`ACSP_A_GAIN_SM: rd_byte = sel_trim.gain_small;
			default: rd_byte = `ACSP_UNMAPPED;
		endcase
		// indexed space without a valid core gives the error byte
		if (rd_addr >= `ACSP_A_OFS_LG && rd_addr <= `ACSP_A_GAIN_SM && !sel_ok) begin
			rd_byte = `ACSP_ERR_BYTE; // see RULE20
		end
	end

	// the first bit goes out on the falling edge after the load
	wire logic [2:0] tx_idx = lsb_first ? bit_cnt_q[2:0] : `ACSP_BYTE_MSB - bit_cnt_q[2:0]; // see RULE7
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tx_q <= 8'h00;
			out_q <= 1'h0;
		end else begin
			if (instr_end || byte_end) begin
				tx_q <= rd_byte; // see RULE11
			end
			if (sclk_fall && in_data) begin
				out_q <= tx_q[tx_idx];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers
	assign serial_in_pin_o = out_q;
	assign serial_out_pin_o = out_q;
	// shared pin only during read data, never in instruction phase
	assign serial_in_pin_oe_o = ~four_wire & in_data & ins_q.rd & ~csn_s; // see RULE25 // see RULE2
	// dedicated output released while deselected so slaves can share
	assign serial_out_pin_oe_o = four_wire & ~csn_s; // see RULE26 // see RULE2
	assign four_wire_enable_o = four_wire;
endmodule : acsp_spi_port

// *** logic/acsp_cfg.svh ***
/*
 * constants of the converter configuration port: register offsets,
 * field positions, reset values and phase lengths.
 * assumes it is included by bare name from the package and the port module.
 */
`ifndef ACSP_CFG_SVH
`define ACSP_CFG_SVH
// register address width and offsets
`define ACSP_ADDR_W 13
`define ACSP_A_PORT 13'h0000
`define ACSP_A_BURST 13'h0002
`define ACSP_A_DIE_ID 13'h0008
`define ACSP_A_DIE_REV 13'h0009
`define ACSP_A_CONV_SEL 13'h0010
`define ACSP_A_OFS_LG 13'h0020
`define ACSP_A_OFS_SM 13'h0021
`define ACSP_A_GAIN_LG 13'h0022
`define ACSP_A_GAIN_MD 13'h0023
`define ACSP_A_GAIN_SM 13'h0024
// port_setup fields
`define ACSP_PS_4W_BIT 7
`define ACSP_PS_LSB_BIT 6
`define ACSP_PS_SRST_BIT 5
`define ACSP_PS_KEEP_MASK 8'hDB
// reset values and fixed answers
`define ACSP_PS_RST 8'h00
`define ACSP_BURST_RST 8'h00
`define ACSP_SEL_RST 8'h00
`define ACSP_ERR_BYTE 8'hAD
`define ACSP_UNMAPPED 8'h00
// instruction layout and phase lengths
`define ACSP_RW_BIT 15
`define ACSP_CNT_HI 14
`define ACSP_CNT_LO 13
`define ACSP_CNT_MANY 2'h3
`define ACSP_INSTR_LAST 4'hF
`define ACSP_BYTE_LAST 4'h7
`define ACSP_BYTE_MSB 3'h7
`define ACSP_GAIN_LG_W 4
`endif

// *** logic/acsp_pkg.sv ***
/*
 * types of the converter configuration port: trim record, decoded
 * instruction and serial state codes.
 * assumes acsp_cfg.svh is on the include path.
 */
`include "acsp_cfg.svh"
package acsp_pkg;
	// trim settings of one converter core
	typedef struct packed {
		logic [7:0] ofs_large;
		logic [7:0] ofs_small;
		logic [`ACSP_GAIN_LG_W-1:0] gain_large;
		logic [7:0] gain_mid;
		logic [7:0] gain_small;
	} acsp_trim_t;
	// decoded two-byte instruction
	typedef struct packed {
		logic rd;
		logic [1:0] cnt;
		logic [`ACSP_ADDR_W-1:0] addr;
	} acsp_instr_t;
	// serial state machine, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_INSTR = 4'h2,
		ST_DATA = 4'h4,
		ST_DONE = 4'h8
	} acsp_state_t;
endpackage : acsp_pkg

// *** verif/acsp_spi_port_chk.sv ***
/* pin-level checker of the configuration port.
   assumes it is bound into acsp_spi_port and sees only its ports. */
`timescale 1ns/1ps
module acsp_spi_port_chk #(
	parameter int NUM_CONV = 2
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// link pins
	input wire logic sclk_i,
	input wire logic chip_select_n_i,
	input wire logic serial_in_pin_i,
	input wire logic serial_in_pin_o,
	input wire logic serial_in_pin_oe_o,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe_o,
	// core side
	input acsp_pkg::acsp_trim_t cal_trim_i [NUM_CONV],
	input acsp_pkg::acsp_trim_t trim_o [NUM_CONV],
	input wire logic four_wire_enable_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// pins let go once deselect has crossed the synchronisers
	a_idle_released: assert property (chip_select_n_i [*6] |-> !serial_in_pin_oe_o && !serial_out_pin_oe_o)
		else $error("data pin driven while deselected");
	a_shared_mode: assert property (four_wire_enable_o |-> !serial_in_pin_oe_o)
		else $error("shared pin driven in four-wire mode");
	a_dedicated_mode: assert property (serial_out_pin_oe_o |-> four_wire_enable_o)
		else $error("dedicated pin driven in three-wire mode");
	a_reset_values: assert property ($fell(rst_i) |-> !four_wire_enable_o && trim_o[0] == cal_trim_i[0])
		else $error("wrong values after reset");
	// a deselected slave never changes its settings on its own
	a_quiet_cfg: assert property (chip_select_n_i [*6] |=> $stable(four_wire_enable_o) && $stable(trim_o[NUM_CONV-1]))
		else $error("settings changed while deselected");
	a_drive_selected: assert property ($rose(serial_in_pin_oe_o) |-> $past(chip_select_n_i, 2) == 1'b0)
		else $error("shared pin driven without select");
	a_sdo_selected: assert property ($rose(serial_out_pin_oe_o) |-> $past(chip_select_n_i, 2) == 1'b0)
		else $error("dedicated pin driven without select");
	// read bit only moves after a falling link clock
	a_bit_steady: assert property ((sclk_i && serial_in_pin_oe_o) [*3] |=> $stable(serial_in_pin_o))
		else $error("read bit moved while link clock high");
endmodule : acsp_spi_port_chk
bind acsp_spi_port acsp_spi_port_chk #(.NUM_CONV(NUM_CONV)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk_i),
	.chip_select_n_i(chip_select_n_i), .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_o(serial_in_pin_o),
	.serial_in_pin_oe_o(serial_in_pin_oe_o), .serial_out_pin_o(serial_out_pin_o),
	.serial_out_pin_oe_o(serial_out_pin_oe_o), .cal_trim_i(cal_trim_i), .trim_o(trim_o),
	.four_wire_enable_o(four_wire_enable_o));

// *** verif/acsp_master_mdl.sv ***
/* master model of the serial link: clock, select and shared data wire.
   assumes mclk_i at 100 MHz; one link clock spans 8 mclk. */
`timescale 1ns/1ps
module acsp_master_mdl (
	// system clock
	input wire logic mclk_i,
	// link toward the port
	output logic sclk_o,
	output logic chip_select_n_o,
	output logic data_o,
	input wire logic pin_i,
	input wire logic pin_oe_i,
	input wire logic out_i,
	input wire logic out_oe_i
);
	logic drv_q = 1'b1; // master drives the shared wire
	logic bit_q = 1'b0; // last bit put out
	logic lsb = 1'b0; // port expects lsb first
	logic fw = 1'b0; // port answers on its dedicated pin
	logic [7:0] dat [8]; // bytes to send, or bytes read
	////////////////////////////////////////
	// one slave on the wire; released line shows the inverse of its last value
	assign data_o = pin_oe_i ? pin_i : (drv_q ? bit_q : !bit_q);
	initial begin
		sclk_o = 1'b0;
		chip_select_n_o = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : wait_n
	// data changes with the falling clock, read bit taken at the rise
	task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
		int k;
		r = '0;
		for (int i = 0; i < n; i++) begin
			k = lsb ? i : n - 1 - i;
			bit_q <= w[k];
			wait_n(4);
			sclk_o <= 1'b1;
			// a released dedicated pin reads inverted, so a missing enable shows up
			r[k] = fw ? (out_oe_i ? out_i : !out_i) : data_o;
			wait_n(4);
			sclk_o <= 1'b0;
		end
	endtask : shift
	// select pause at a byte boundary; sclk stays low meanwhile
	task automatic pause();
		wait_n(4);
		chip_select_n_o <= 1'b1;
		wait_n(8);
		chip_select_n_o <= 1'b0;
	endtask : pause
	// stop cuts that data byte after four bits; pz pauses select inside the instruction and before data
	task automatic txn(input logic rd, input logic [1:0] c, input logic [12:0] a, input int nb, input int stop = 9,
		input logic pz = 1'b0);
		logic [15:0] r;
		logic [15:0] w;
		w = {rd, c, a};
		drv_q <= 1'b1;
		chip_select_n_o <= 1'b0;
		shift(lsb ? w : w >> 8, 8, r);
		if (pz)
			pause();
		shift(lsb ? w >> 8 : w, 8, r);
		drv_q <= !rd;
		if (pz)
			pause();
		for (int b = 0; b < nb; b++) begin
			shift({8'h00, dat[b]}, (b == stop) ? 4 : 8, r);
			if (rd)
				dat[b] = r[7:0];
		end
		wait_n(4);
		chip_select_n_o <= 1'b1;
		drv_q <= 1'b1;
		wait_n(8);
	endtask : txn
endmodule : acsp_master_mdl

// *** verif/tb_acsp_spi_port.sv ***
/* self-checking bench of the configuration port.
   assumes the package, header and master model are compiled first. */
`timescale 1ns/1ps
`include "acsp_cfg.svh"
module tb_acsp_spi_port;
	localparam logic [7:0] ID = 8'hC3; // arbitrary value
	localparam logic [7:0] REV = 8'h17; // arbitrary value
	logic mclk_i;
	logic rst_i;
	logic sclk, csn, din, pin_o, pin_oe, serial_out_pin, sdo_oe, fw;
	acsp_pkg::acsp_trim_t cal [2];
	acsp_pkg::acsp_trim_t trim [2];
	logic [7:0] v [5]; // expected trim bytes of core 0
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 32'hc9aee2ac;
	////////////////////////////////////////
	acsp_spi_port #(.NUM_CONV(2), .DIE_ID(ID), .DIE_REV(REV)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk),
		.chip_select_n_i(csn), .serial_in_pin_i(din), .serial_in_pin_o(pin_o), .serial_in_pin_oe_o(pin_oe),
		.serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(sdo_oe), .cal_trim_i(cal), .trim_o(trim), .four_wire_enable_o(fw));
	acsp_master_mdl m (.mclk_i(mclk_i), .sclk_o(sclk), .chip_select_n_o(csn), .data_o(din), .pin_i(pin_o),
		.pin_oe_i(pin_oe), .out_i(serial_out_pin), .out_oe_i(sdo_oe));
	////////////////////////////////////////
	// port setup value that reads the same in either bit order
	function automatic logic [7:0] ps_val(input logic f, input logic l, input logic s);
		return {f, l, s, 1'b1, 1'b1, s, l, f};
	endfunction : ps_val
	function automatic acsp_pkg::acsp_trim_t exp_trim();
		return {v[0], v[1], v[2][3:0], v[3], v[4]};
	endfunction : exp_trim
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// a hang counts as a mismatch
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		rst_i = 1'b1;
		for (int i = 0; i < 2; i++)
			cal[i] = 36'({$random(seed), $random(seed)});
		for (int i = 0; i < 5; i++)
			v[i] = 8'($random(seed));
		// coarse gain takes only its seven defined codes
		if ($random(seed) & 1)
			v[2] = {4'h0, 2'($random(seed)), 2'h0};
		else
			v[2] = {6'h00, 2'($random(seed))};
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		m.txn(1'b1, 2'h1, `ACSP_A_DIE_ID, 2);
		chk(m.dat[0], ID);
		chk(m.dat[1], REV);
		m.txn(1'b1, 2'h0, `ACSP_A_CONV_SEL, 1);
		chk(m.dat[0], 8'h00);
		m.txn(1'b1, 2'h0, `ACSP_A_OFS_LG, 1);
		chk(m.dat[0], 8'hAD);
		// select core 0 with a pause before the data byte
		m.dat[0] = 8'h01;
		m.txn(1'b0, 2'h0, `ACSP_A_CONV_SEL, 1, 9, 1'b1);
		m.dat[0] = 8'h23;
		m.txn(1'b0, 2'h0, `ACSP_A_BURST, 1);
		for (int i = 0; i < 5; i++)
			m.dat[i] = v[i];
		m.txn(1'b0, 2'h3, `ACSP_A_OFS_LG, 5);
		v[4] = cal[0].gain_small;
		chk(trim[0], exp_trim());
		chk(trim[1], cal[1]);
		m.txn(1'b1, 2'h3, `ACSP_A_OFS_LG, 4);
		for (int i = 0; i < 4; i++)
			chk(m.dat[i], (i == 2) ? {4'h0, v[2][3:0]} : v[i]);
		m.dat[0] = ~v[3];
		m.dat[1] = ~v[4];
		m.txn(1'b0, 2'h0, `ACSP_A_GAIN_MD, 2);
		v[3] = ~v[3];
		chk(trim[0], exp_trim());
		// three-byte count: the fourth byte must not reach gain_trim_mid
		m.dat[0] = ~v[0];
		m.dat[1] = ~v[1];
		m.dat[2] = v[2];
		m.dat[3] = ~v[3];
		m.txn(1'b0, 2'h2, `ACSP_A_OFS_LG, 4);
		v[0] = ~v[0];
		v[1] = ~v[1];
		chk(trim[0], exp_trim());
		m.dat[0] = 8'h03;
		m.txn(1'b0, 2'h0, `ACSP_A_CONV_SEL, 1);
		m.txn(1'b1, 2'h0, `ACSP_A_OFS_SM, 1);
		chk(m.dat[0], 8'hAD);
		// select lost in mid-byte leaves the register alone
		m.dat[0] = 8'h02;
		m.txn(1'b0, 2'h0, `ACSP_A_CONV_SEL, 1, 0);
		m.txn(1'b1, 2'h0, `ACSP_A_CONV_SEL, 1);
		chk(m.dat[0], 8'h03);
		m.dat[0] = ps_val(1'b0, 1'b1, 1'b0);
		m.txn(1'b0, 2'h0, `ACSP_A_PORT, 1);
		m.lsb = 1'b1;
		m.txn(1'b1, 2'h1, `ACSP_A_DIE_REV, 2);
		chk(m.dat[0], REV);
		chk(m.dat[1], ID);
		m.dat[0] = ps_val(1'b1, 1'b1, 1'b0);
		m.txn(1'b0, 2'h0, `ACSP_A_PORT, 1);
		chk(fw, 1'b1);
		m.fw = 1'b1;
		m.txn(1'b1, 2'h0, `ACSP_A_PORT, 1);
		chk(m.dat[0], ps_val(1'b1, 1'b1, 1'b0));
		m.dat[0] = ps_val(1'b0, 1'b1, 1'b1);
		m.txn(1'b0, 2'h0, `ACSP_A_PORT, 1);
		m.fw = 1'b0;
		m.lsb = 1'b0;
		chk(fw, 1'b0);
		chk(trim[0], cal[0]);
		m.txn(1'b1, 2'h0, `ACSP_A_CONV_SEL, 1);
		chk(m.dat[0], 8'h00);
		close_out();
	end
endmodule : tb_acsp_spi_port
